// ### bil_boot_loader.sv
// Boot sequencer and image loader: picks boot source, streams a
// length-prefixed image into RAM, checks CRC and starts the program.
// Assumes memory ports answer byte reads with a one-cycle-or-later valid
// pulse, and RAM accepts a word write in one cycle.
//
// Function
// (RL1) Held in reset while reset pin low
// (RL2) Pull-downs on all GPIO during reset
// (RL3) Reset held 1 ms after supply good (no timer here; bench holds pin low 1 ms)
// (RL4) Internal reset, then boot after delay
// (RL5) Security bit 5 selects OTP boot
// (RL6) Otherwise read embedded QSPI flash
// (RL7) Size word, program words, trailer word
// (RL8) Skip marker trailer disables CRC check
// (RL9) Size and trailer LSB first
// (RL10) Load at RAM base, start there
// (RL11) CRC over size and program bytes
// (RL12) Reflected CRC-32, preset ones, inverted
// (RL13) Secure boot from OTP address 0
// (RL14) Security register loaded from OTP first
// (RL15) CRC mismatch: no start, flag failure
`timescale 1ns/1ps
module bil_boot_loader
   import bil_pkg::*;
#(
   parameter int unsigned GPIO_W = 42,
   parameter int unsigned BOOT_DLY_CYC = BIL_BOOT_DLY_CYC
) (
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   input wire logic rst_i,
   output logic [GPIO_W-1:0] gpio_pd_en_o,
   output logic otp_rd_o,
   output logic [31:0] otp_addr_o,
   input wire logic otp_vld_i,
   input wire logic [7:0] otp_data_i,
   output logic flash_rd_o,
   output logic [31:0] flash_addr_o,
   input wire logic flash_vld_i,
   input wire logic [7:0] flash_data_i,
   output logic ram_we_o,
   output logic [31:0] ram_addr_o,
   output logic [31:0] ram_data_o,
   output logic sec_boot_o,
   output logic [31:0] sec_reg_o,
   output logic run_o,
   output logic [31:0] run_addr_o,
   output logic boot_fail_o,
   output logic busy_o
);
   // Refuse sizes the counters cannot serve
   if (GPIO_W < 1 || BOOT_DLY_CYC < 1) begin : g_bad_param
      $error("bil_boot_loader: bad parameter");
   end

   // ----------------------------------------
   // Reset pin synchroniser
   // ----------------------------------------
   logic rstn_s1_r;
   logic rstn_s2_r;
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         rstn_s1_r <= 1'b0;
         rstn_s2_r <= 1'b0;
      end else begin
         rstn_s1_r <= rst_n_i;
         rstn_s2_r <= rstn_s1_r;
      end
   end

   // ----------------------------------------
   // Sequencer state
   // ----------------------------------------
   bil_state_e state_r;
   logic [31:0] dly_r;
   logic [1:0] bcnt_r;
   logic [31:0] sh_r;
   logic [31:0] size_r;
   logic [31:0] wcnt_r;
   logic [31:0] src_addr_r;
   logic rd_pend_r;
   logic sec_done_r;

   logic byte_vld;
   logic [7:0] byte_dat;
   logic [31:0] word_asm;
   logic word_done;
   logic [31:0] crc_val;
   logic crc_init;
   logic crc_feed;

   // (RL5) Source select by security bit
   assign byte_vld = sec_done_r ? (sec_reg_o[BIL_SEC_BOOT_BIT] ?
                     otp_vld_i : flash_vld_i) : otp_vld_i;
   assign byte_dat = sec_done_r ? (sec_reg_o[BIL_SEC_BOOT_BIT] ?
                     otp_data_i : flash_data_i) : otp_data_i;
   // (RL9) Least significant byte first
   assign word_asm = {byte_dat, sh_r[31:8]};
   assign word_done = byte_vld && (bcnt_r == 2'h3);
   assign crc_init = (state_r == BIL_ST_SEC);
   // (RL11) Trailer excluded from CRC
   assign crc_feed = byte_vld &&
                     (state_r == BIL_ST_SIZE || state_r == BIL_ST_PROG);

   bil_crc_byte u_crc (
      .sys_clk_i(sys_clk_i),
      .rst_i(rst_i),
      .init_i(crc_init),
      .byte_vld_i(crc_feed),
      .byte_i(byte_dat),
      .crc_o(crc_val)
   );

   logic reading;
   assign reading = (state_r == BIL_ST_SEC || state_r == BIL_ST_SIZE ||
                     state_r == BIL_ST_PROG || state_r == BIL_ST_TRAIL);

   // (RL1) Pin low forces reset state
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         state_r <= BIL_ST_RESET;
         dly_r <= 32'h00000000;
         bcnt_r <= 2'h0;
         sh_r <= 32'h00000000;
         size_r <= 32'h00000000;
         wcnt_r <= 32'h00000000;
         sec_done_r <= 1'b0;
         sec_reg_o <= 32'h00000000;
      end else if (!rstn_s2_r) begin
         state_r <= BIL_ST_RESET;
         dly_r <= 32'h00000000;
         bcnt_r <= 2'h0;
         sec_done_r <= 1'b0;
      end else begin
         if (byte_vld && reading) begin
            sh_r <= word_asm;
            bcnt_r <= bcnt_r + 2'h1;
         end
         case (state_r)
            BIL_ST_RESET: begin
               state_r <= BIL_ST_WAIT;
            end
            // (RL4) Internal reset delay
            BIL_ST_WAIT: begin
               if (dly_r == BOOT_DLY_CYC - 1) begin
                  state_r <= BIL_ST_SEC;
               end else begin
                  dly_r <= dly_r + 32'h00000001;
               end
            end
            // (RL14) Security word from OTP
            BIL_ST_SEC: begin
               if (word_done) begin
                  sec_reg_o <= word_asm;
                  sec_done_r <= 1'b1;
                  state_r <= BIL_ST_SIZE;
               end
            end
            // (RL7) Size word
            BIL_ST_SIZE: begin
               if (word_done) begin
                  size_r <= word_asm;
                  wcnt_r <= 32'h00000000;
                  state_r <= (word_asm == 32'h00000000) ?
                             BIL_ST_TRAIL : BIL_ST_PROG;
               end
            end
            BIL_ST_PROG: begin
               if (word_done) begin
                  wcnt_r <= wcnt_r + 32'h00000001;
                  if (wcnt_r + 32'h00000001 == size_r) begin
                     state_r <= BIL_ST_TRAIL;
                  end
               end
            end
            // (RL8) Skip marker or CRC compare
            BIL_ST_TRAIL: begin
               if (word_done) begin
                  state_r <= (word_asm == BIL_NO_CRC_MARK ||
                              word_asm == crc_val) ? BIL_ST_RUN : BIL_ST_FAIL;
               end
            end
            BIL_ST_RUN: state_r <= BIL_ST_RUN;
            BIL_ST_FAIL: state_r <= BIL_ST_FAIL;
            default: state_r <= BIL_ST_RESET;
         endcase
      end
   end

   // ----------------------------------------
   // Memory read requests
   // ----------------------------------------
   // One read outstanding keeps byte order trivially correct
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         rd_pend_r <= 1'b0;
         src_addr_r <= 32'h00000000;
         otp_rd_o <= 1'b0;
         flash_rd_o <= 1'b0;
         otp_addr_o <= 32'h00000000;
         flash_addr_o <= 32'h00000000;
      end else begin
         otp_rd_o <= 1'b0;
         flash_rd_o <= 1'b0;
         if (!rstn_s2_r || state_r == BIL_ST_WAIT) begin
            rd_pend_r <= 1'b0;
            src_addr_r <= BIL_SEC_ADDR;
         end else if (byte_vld) begin
            rd_pend_r <= 1'b0;
            // (RL13) OTP image from address 0
            if (state_r == BIL_ST_SEC) begin
               src_addr_r <= word_done ? (word_asm[BIL_SEC_BOOT_BIT] ?
                  BIL_OTP_IMG_ADDR : BIL_FLASH_IMG_ADDR) :
                  src_addr_r + 32'h00000001;
            end else begin
               src_addr_r <= src_addr_r + 32'h00000001;
            end
         end else if (reading && !rd_pend_r) begin
            rd_pend_r <= 1'b1;
            // (RL6) Flash unless secure boot
            if (!sec_done_r || sec_reg_o[BIL_SEC_BOOT_BIT]) begin
               otp_rd_o <= 1'b1;
               otp_addr_o <= src_addr_r;
            end else begin
               flash_rd_o <= 1'b1;
               flash_addr_o <= src_addr_r;
            end
         end
      end
   end

   // ----------------------------------------
   // RAM writes and outputs
   // ----------------------------------------
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         ram_we_o <= 1'b0;
         ram_addr_o <= BIL_RAM_BASE;
         ram_data_o <= 32'h00000000;
      end else begin
         ram_we_o <= 1'b0;
         // (RL10) Words from RAM base upward
         if (rstn_s2_r && state_r == BIL_ST_PROG && word_done) begin
            ram_we_o <= 1'b1;
            ram_addr_o <= BIL_RAM_BASE + {wcnt_r[29:0], 2'b00};
            ram_data_o <= word_asm;
         end
      end
   end

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         gpio_pd_en_o <= '1;
         run_o <= 1'b0;
         run_addr_o <= BIL_RAM_BASE;
         boot_fail_o <= 1'b0;
         busy_o <= 1'b0;
         sec_boot_o <= 1'b0;
      end else begin
         // (RL2) Pull-downs while in reset
         gpio_pd_en_o <= {GPIO_W{!rstn_s2_r || state_r == BIL_ST_RESET}};
         // (RL10) Start at load address
         run_o <= rstn_s2_r && state_r == BIL_ST_RUN;
         run_addr_o <= BIL_RAM_BASE;
         // (RL15) Mismatch flags failure
         boot_fail_o <= rstn_s2_r && state_r == BIL_ST_FAIL;
         busy_o <= rstn_s2_r && state_r != BIL_ST_RUN &&
                   state_r != BIL_ST_FAIL;
         sec_boot_o <= sec_done_r && sec_reg_o[BIL_SEC_BOOT_BIT];
      end
   end
endmodule : bil_boot_loader

// ### bil_boot_loader_assertions.sv
// Port checker for the boot loader.
// Assumes one clock and rst_i as async reset.
`timescale 1ns/1ps
module bil_boot_loader_assertions
   import bil_pkg::*;
#(
   parameter int unsigned GPIO_W = 42,
   parameter int unsigned BOOT_DLY_CYC = BIL_BOOT_DLY_CYC
) (
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   input wire logic rst_i,
   input wire logic [GPIO_W-1:0] gpio_pd_en_o,
   input wire logic otp_rd_o,
   input wire logic flash_rd_o,
   input wire logic sec_boot_o,
   input wire logic run_o,
   input wire logic [31:0] run_addr_o,
   input wire logic boot_fail_o
);
   logic [15:0] wait_cnt_r;
   logic seen_rd_r;
   logic [2:0] rd_cnt_r;
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);
   // ----------------------------------------
   // Counters since the pin went high
   // ----------------------------------------
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         wait_cnt_r <= 16'h0;
         seen_rd_r <= 1'b0;
         rd_cnt_r <= 3'h0;
      end else if (!rst_n_i) begin
         wait_cnt_r <= 16'h0;
         seen_rd_r <= 1'b0;
         rd_cnt_r <= 3'h0;
      end else begin
         wait_cnt_r <= wait_cnt_r + {15'h0, !seen_rd_r};
         seen_rd_r <= seen_rd_r | otp_rd_o;
         rd_cnt_r <= rd_cnt_r + {2'h0, otp_rd_o && rd_cnt_r != 3'h4};
      end
   end
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   AST_PD_IN_RESET: assert property (!rst_n_i [*5] |-> &gpio_pd_en_o)
      else $error("pull-downs off in reset");
   AST_HALT_IN_RESET: assert property (!rst_n_i [*5] |-> !run_o)
      else $error("running in reset");
   AST_BOOT_DELAY: assert property (rst_n_i && !seen_rd_r |->
      wait_cnt_r <= BOOT_DLY_CYC + 6 &&
      (!otp_rd_o || wait_cnt_r >= BOOT_DLY_CYC))
      else $error("boot delay out of range");
   AST_RD_PULSE: assert property (otp_rd_o |=> !otp_rd_o)
      else $error("read request longer than one cycle");
   AST_FLASH_SRC: assert property (flash_rd_o |->
      rd_cnt_r == 3'h4 && !sec_boot_o)
      else $error("flash read before security word or in secure boot");
   AST_RUN_ADDR: assert property ($rose(run_o) |->
      run_addr_o == BIL_RAM_BASE)
      else $error("start address not RAM base");
   AST_RUN_XOR_FAIL: assert property (boot_fail_o |-> !run_o)
      else $error("run and fail together");
   AST_RUN_HOLD: assert property (run_o && rst_n_i |=> run_o)
      else $error("run dropped without reset");
endmodule : bil_boot_loader_assertions

bind bil_boot_loader bil_boot_loader_assertions #(.GPIO_W(GPIO_W),
   .BOOT_DLY_CYC(BOOT_DLY_CYC)) i_chk (.sys_clk_i(sys_clk_i),
   .rst_n_i(rst_n_i), .rst_i(rst_i), .gpio_pd_en_o(gpio_pd_en_o),
   .otp_rd_o(otp_rd_o), .flash_rd_o(flash_rd_o), .sec_boot_o(sec_boot_o),
   .run_o(run_o), .run_addr_o(run_addr_o), .boot_fail_o(boot_fail_o));

// ### bil_crc_byte.sv
// Reflected CRC-32 step over one byte, one byte per clock.
// Assumes caller presents bytes in stream order with a valid strobe.
`timescale 1ns/1ps
module bil_crc_byte
   import bil_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic init_i,
   input wire logic byte_vld_i,
   input wire logic [7:0] byte_i,
   output logic [31:0] crc_o
);
   logic [31:0] crc_r;
   logic [31:0] crc_nxt;

   // ----------------------------------------
   // Bitwise LSB-first update
   // ----------------------------------------
   always_comb begin
      crc_nxt = crc_r ^ {24'h000000, byte_i};
      for (int i = 0; i < 8; i++) begin
         if (crc_nxt[0]) begin
            crc_nxt = (crc_nxt >> 1) ^ BIL_CRC_POLY;
         end else begin
            crc_nxt = crc_nxt >> 1;
         end
      end
   end

   // (RL12) Preset and update
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         crc_r <= BIL_CRC_PRESET;
      end else if (init_i) begin
         crc_r <= BIL_CRC_PRESET;
      end else if (byte_vld_i) begin
         crc_r <= crc_nxt;
      end
   end

   // (RL12) Residue inverted
   assign crc_o = ~crc_r;
endmodule : bil_crc_byte

// ### bil_mem_model.sv
// Byte memory standing in for OTP or flash.
// Assumes one read outstanding; answers 1 to 4 cycles late.
`timescale 1ns/1ps
module bil_mem_model (
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   input wire logic rd_i,
   input wire logic [31:0] addr_i,
   input wire logic [1:0] lat_i,
   output logic vld_o,
   output logic [7:0] data_o
);
   logic [7:0] mem [0:1023];
   logic [31:0] addr_r;
   logic [1:0] wait_r;
   logic pend_r = 1'b0;
   initial vld_o = 1'b0;
   initial data_o = 8'hA5;
   always @(posedge sys_clk_i) begin
      vld_o <= 1'b0;
      // Released bus shows no stale byte
      if (vld_o) data_o <= ~data_o;
      if (!rst_n_i) begin
         pend_r <= 1'b0;
      end else if (rd_i) begin
         pend_r <= 1'b1;
         wait_r <= lat_i;
         addr_r <= addr_i;
      end else if (pend_r && wait_r != 2'h0) begin
         wait_r <= wait_r - 2'h1;
      end else if (pend_r) begin
         pend_r <= 1'b0;
         vld_o <= 1'b1;
         data_o <= mem[addr_r[9:0]];
      end
   end
endmodule : bil_mem_model

// ### bil_pkg.sv
// Constants shared by the boot image loader and its CRC engine.
// Assumes a single 50 MHz system clock.
package bil_pkg;
   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int unsigned BIL_CLK_HZ = 50000000;
   localparam int unsigned BIL_BOOT_DLY_MIN_US = 15;
   localparam int unsigned BIL_BOOT_DLY_MAX_US = 150;
   localparam int unsigned BIL_BOOT_DLY_CYC =
      (BIL_BOOT_DLY_MIN_US * (BIL_CLK_HZ / 1000000));
   // ----------------------------------------
   // Image format
   // ----------------------------------------
   localparam logic [31:0] BIL_NO_CRC_MARK = 32'h0D15AB1E;
   localparam logic [31:0] BIL_CRC_POLY = 32'hEDB88320;
   localparam logic [31:0] BIL_CRC_PRESET = 32'hFFFFFFFF;
   localparam int unsigned BIL_SEC_BOOT_BIT = 5;
   localparam int unsigned BIL_SEC_W = 32;
   localparam logic [31:0] BIL_SEC_ADDR = 32'h00000000;
   localparam logic [31:0] BIL_OTP_IMG_ADDR = 32'h00000000;
   localparam logic [31:0] BIL_FLASH_IMG_ADDR = 32'h00000000;
   localparam logic [31:0] BIL_RAM_BASE = 32'h00000000;
   // ----------------------------------------
   // States
   // ----------------------------------------
   typedef enum logic [3:0] {
      BIL_ST_RESET = 4'h0,
      BIL_ST_WAIT = 4'h1,
      BIL_ST_SEC = 4'h2,
      BIL_ST_SIZE = 4'h3,
      BIL_ST_PROG = 4'h4,
      BIL_ST_TRAIL = 4'h5,
      BIL_ST_CHECK = 4'h6,
      BIL_ST_RUN = 4'h7,
      BIL_ST_FAIL = 4'h8
   } bil_state_e;
endpackage : bil_pkg

// ### testbench.sv
// Boot loader bench: flash and secure boots, skip marker, bad
// checksum, empty image, aborted start. Memories are models.
`timescale 1ns/1ps
module testbench
   import bil_pkg::*;
();
   logic sys_clk_i, rst_i, rst_n_i, ram_we, run, fail, sec_boot, busy;
   logic otp_rd, otp_vld, fl_rd, fl_vld;
   logic [31:0] otp_a, fl_a, ram_a, ram_d, sec_reg, run_a, sec_exp;
   logic [7:0] otp_d, fl_d;
   logic [41:0] pd_en;
   logic [1:0] otp_lat, fl_lat;
   logic [63:0] exp_q [$];
   int n_mismatch = 0;
   int cmp_count = 0;
   // 1 ms at 50 MHz
   localparam int PWR_HOLD_CYC = 50000;
   bil_boot_loader #(.GPIO_W(42), .BOOT_DLY_CYC(4)) i_dut (
      .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .rst_i(rst_i),
      .gpio_pd_en_o(pd_en), .otp_rd_o(otp_rd), .otp_addr_o(otp_a),
      .otp_vld_i(otp_vld), .otp_data_i(otp_d), .flash_rd_o(fl_rd),
      .flash_addr_o(fl_a), .flash_vld_i(fl_vld), .flash_data_i(fl_d),
      .ram_we_o(ram_we), .ram_addr_o(ram_a), .ram_data_o(ram_d),
      .sec_boot_o(sec_boot), .sec_reg_o(sec_reg), .run_o(run),
      .run_addr_o(run_a), .boot_fail_o(fail), .busy_o(busy));
   bil_mem_model i_otp (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
      .rd_i(otp_rd), .addr_i(otp_a), .lat_i(otp_lat), .vld_o(otp_vld),
      .data_o(otp_d));
   bil_mem_model i_fl (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
      .rd_i(fl_rd), .addr_i(fl_a), .lat_i(fl_lat), .vld_o(fl_vld),
      .data_o(fl_d));
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic close_out();
      $display("compares=%0d mismatches=%0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : close_out
   function automatic logic [31:0] crc_upd(logic [31:0] c, logic [7:0] b);
      c = c ^ {24'h0, b};
      for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ BIL_CRC_POLY : c >> 1;
      return c;
   endfunction : crc_upd
   // Least byte first into the chosen memory
   task automatic put(input bit otp, input int a, input logic [31:0] w);
      for (int k = 0; k < 4; k++) begin
         if (otp) i_otp.mem[a + k] = w[8*k +: 8];
         else i_fl.mem[a + k] = w[8*k +: 8];
      end
   endtask : put
   // Mode 0 good checksum, 1 skip marker, 2 corrupted checksum
   task automatic build(input bit sec, input int nw, input int mode);
      logic [31:0] w;
      logic [31:0] crc;
      sec_exp = sec ? 32'h00000020 : ($urandom() & 32'hFFFFFFDF);
      put(1'b1, 0, sec_exp);
      w = 32'(nw);
      put(sec, 0, w);
      crc = BIL_CRC_PRESET;
      for (int k = 0; k < 4; k++) crc = crc_upd(crc, w[8*k +: 8]);
      for (int i = 0; i < nw; i++) begin
         w = $urandom();
         put(sec, 4 + 4 * i, w);
         exp_q.push_back({BIL_RAM_BASE + 32'(4 * i), w});
         for (int k = 0; k < 4; k++) crc = crc_upd(crc, w[8*k +: 8]);
      end
      w = (mode == 1) ? BIL_NO_CRC_MARK : ~crc ^ 32'(mode == 2);
      put(sec, 4 + 4 * nw, w);
   endtask : build
   task automatic run_boot(input string name, input bit bad, input int ab);
      int n;
      otp_lat = 2'($urandom_range(3));
      fl_lat = 2'($urandom_range(3));
      rst_n_i = 1'b0;
      repeat (6) @(negedge sys_clk_i);
      chk(64'(pd_en), 64'h3FFFFFFFFFF);
      chk(busy, 1'b0);
      rst_n_i = 1'b1;
      if (ab > 0) begin
         repeat (ab) @(negedge sys_clk_i);
         chk(busy, 1'b1);
         rst_n_i = 1'b0;
         repeat (6) @(negedge sys_clk_i);
         chk(64'(run), 64'h0);
         rst_n_i = 1'b1;
      end
      n = 0;
      while (run !== 1'b1 && fail !== 1'b1 && n < 5000) begin
         @(negedge sys_clk_i);
         n++;
      end
      if (n >= 5000) begin
         n_mismatch++;
         $display("timeout in %s", name);
         close_out();
      end
      repeat (3) @(negedge sys_clk_i);
      chk({run, fail}, {!bad, bad});
      chk(64'(exp_q.size()), 64'h0);
      chk(sec_reg, sec_exp);
      chk(sec_boot, sec_exp[5]);
      chk(run_a, BIL_RAM_BASE);
      chk(64'(pd_en), 64'h0);
      chk(busy, 1'b0);
      $display("test %s done", name);
   endtask : run_boot
   always @(posedge sys_clk_i) begin
      if (ram_we === 1'b1 && exp_q.size() == 0) chk(64'h1, 64'h0);
      else if (ram_we === 1'b1) chk({ram_a, ram_d}, exp_q.pop_front());
   end
   initial begin
      sys_clk_i = 1'b0;
      forever #10 sys_clk_i = ~sys_clk_i;
   end
   initial begin
      rst_i = 1'b1;
      rst_n_i = 1'b0;
      otp_lat = 2'h0;
      fl_lat = 2'h0;
      void'($urandom(32'h9B8B));
      repeat (10) @(negedge sys_clk_i);
      rst_i = 1'b0;
      // supply good from start, pin held low 1 ms
      repeat (PWR_HOLD_CYC) @(negedge sys_clk_i);
      build(0, 3, 0);
      run_boot("crc_ok", 0, 0);
      build(0, 5, 1);
      run_boot("skip", 0, 0);
      build(0, 2, 2);
      run_boot("bad_crc", 1, 0);
      build(0, 0, 0);
      run_boot("empty", 0, 0);
      build(0, 4, 0);
      run_boot("abort", 0, 12);
      build(1, 32, 0);
      run_boot("secure", 0, 0);
      close_out();
   end
endmodule : testbench
